// ===== bench/ieb_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checks for the enable bank
module ieb_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ieb_pkg::ieb_addr_t reg_addr,
  input wire ieb_pkg::ieb_byte_t reg_wdata,
  input wire ieb_pkg::ieb_byte_t reg_rdata,
  input wire logic reg_rvalid,
  input wire logic conv_pll_lock_indicator,
  input wire logic link_pll_lock_indicator,
  input wire logic link_enable,
  input wire ieb_pkg::ieb_lanes_t lane_fifo_full,
  input wire ieb_pkg::ieb_lanes_t lane_fifo_empty,
  input wire ieb_pkg::ieb_prbs_t prbs_err,
  input wire logic irq
);
  logic [7:0] en0;
  logic [3:0] en1;
  logic live;
  always_ff @(posedge clk) live <= !sys_rst;
  always_ff @(posedge clk)
    if (sys_rst) en0 <= 8'h00;
    else if (reg_wr && reg_addr == 12'h01f) en0 <= reg_wdata;
  always_ff @(posedge clk)
    if (sys_rst) en1 <= 4'h0;
    else if (reg_wr && reg_addr == 12'h020) en1 <= reg_wdata[3:0];
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_read_latency: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray rvalid");
  a_rdata_hold: assert property (live && !reg_rvalid
    |-> $stable(reg_rdata)) else $error("rdata moved");
  a_en0_read: assert property (reg_rd && reg_addr == 12'h01f
    |=> reg_rdata == $past(en0)) else $error("en0 rd");
  a_en1_read: assert property (reg_rd && reg_addr == 12'h020
    |=> reg_rdata == {4'h0, $past(en1)}) else $error("en1 rd");
  a_irq_cause: assert property (irq
    |-> ($past(en0) & 8'h3e) != 8'h00 || $past(en1) != 4'h0) else $error("irq unenabled");
  a_conv_loss: assert property (live && $fell(conv_pll_lock_indicator) && en0[5] && !reg_wr
    |=> ##1 irq) else $error("conv loss");
  a_conv_lock: assert property (live && $rose(conv_pll_lock_indicator) && en0[4] && !reg_wr
    |=> ##1 irq) else $error("conv lock");
  a_link_loss: assert property (live && $fell(link_pll_lock_indicator) && en0[3] && !reg_wr
    |=> ##1 irq) else $error("link loss");
  a_link_lock: assert property (live && $rose(link_pll_lock_indicator) && en0[2] && !reg_wr
    |=> ##1 irq) else $error("link lock");
  a_prbs_irq: assert property ((prbs_err & en1) != 4'h0 && !reg_wr
    |=> ##1 irq) else $error("checker irq");
  a_lane_irq: assert property (live && link_enable && $past(link_enable)
    && (lane_fifo_full | lane_fifo_empty) != 8'h00 && en0[1] && !reg_wr ##1 link_enable && !reg_wr
    |=> ##1 irq) else $error("lane irq");
endmodule
`default_nettype wire

// ===== bench/irq_enable_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module irq_enable_bank_tb_top;
  logic clk, sys_rst, reg_wr, reg_rd, conv_i, link_i, link_en, irq, rvalid, run;
  ieb_pkg::ieb_addr_t addr;
  ieb_pkg::ieb_byte_t wdata, rdata;
  ieb_pkg::ieb_lanes_t full, empty;
  ieb_pkg::ieb_prbs_t perr;
  logic [7:0] m_en0, m_f0, m_rd, m_sf, m_se;
  logic [3:0] m_en1, m_f1;
  logic m_err, m_irq, m_rv, p_c, p_l, p_le;
  logic [31:0] seed, r, s;
  logic [11:0] adr [8] = '{12'h01f, 12'h020, 12'h0f0, 12'h0f1, 12'h30c, 12'h30d, 12'h7ff, 12'h021};
  int failures, checks_done, cycles;
  ieb_top u_dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .conv_pll_lock_indicator(conv_i), .link_pll_lock_indicator(link_i),
    .link_enable(link_en), .lane_fifo_full(full), .lane_fifo_empty(empty), .prbs_err(perr), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] rd_val(input logic [11:0] a);
    case (a)
      12'h01f: return m_en0;
      12'h020: return {4'h0, m_en1};
      12'h0f0: return {m_f0[7:2], m_err, m_f0[0]};
      12'h0f1: return {4'h0, m_f1};
      12'h30c: return m_sf;
      12'h30d: return m_se;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("TB: checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic rd, input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr <= w;
    reg_rd <= rd;
    addr <= a;
    wdata <= d;
    @(negedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  // ==========
  // reference model, updated from pre-edge state
  always @(posedge clk) begin
    if (sys_rst) begin
      {m_en0, m_en1, m_f0, m_f1, m_sf, m_se, m_rd} = '0;
      {m_err, m_irq, m_rv, p_c, p_l, p_le} = '0;
    end else begin
      m_irq = |({m_f0[7:2], m_err, m_f0[0]} & m_en0) | |(m_f1 & m_en1);
      m_rv = reg_rd;
      if (reg_rd) m_rd = rd_val(addr);
      m_err = |(m_sf | m_se) && !(link_en && !p_le);
      if (link_en && !p_le) {m_sf, m_se} = '0;
      m_sf = m_sf | (full & {8{link_en}});
      m_se = m_se | (empty & {8{link_en}});
      if (reg_wr && addr == 12'h0f0) m_f0 = m_f0 & ~(wdata & 8'h3c);
      m_f0 = m_f0 | {2'b0, p_c & !conv_i, !p_c & conv_i, p_l & !link_i, !p_l & link_i, 2'b0};
      if (reg_wr && addr == 12'h0f1) m_f1 = m_f1 & ~wdata[3:0];
      m_f1 = m_f1 | perr;
      if (reg_wr && addr == 12'h01f) m_en0 = wdata;
      if (reg_wr && addr == 12'h020) m_en1 = wdata[3:0];
      {p_c, p_l, p_le} = {conv_i, link_i, link_en};
    end
  end
  always @(negedge clk) begin
    if (run) begin
      chk({7'h0, rvalid}, {7'h0, m_rv});
      chk({7'h0, irq}, {7'h0, m_irq});
      if (m_rv) chk(rdata, m_rd);
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  // ==========
  // directed map walk, then random traffic
  initial begin
    {reg_wr, reg_rd, conv_i, link_i, link_en, run, addr, wdata, full, empty, perr} = '0;
    sys_rst = 1'b1;
    seed = 32'h5470ae06;
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst <= 1'b0;
    run <= 1'b1;
    foreach (adr[i]) acc(1'b0, 1'b1, adr[i], 8'h00);
    foreach (adr[i]) acc(1'b1, 1'b1, adr[i], 8'hff);
    foreach (adr[i]) acc(1'b0, 1'b1, adr[i], 8'h00);
    repeat (2) begin
      repeat (2000) begin
        @(negedge clk);
        r = rnd();
        s = rnd();
        link_en <= (r[9:5] == 5'h00) ? !link_en : link_en;
        full <= ((r[9:5] != 5'h00) && link_en) ? r[31:24] & r[23:16] & s[7:0] : 8'h00;
        empty <= ((r[9:5] != 5'h00) && link_en) ? r[23:16] & r[15:8] & s[15:8] : 8'h00;
        conv_i <= conv_i ^ (r[2:0] == 3'h0);
        link_i <= link_i ^ (r[4:3] == 2'h0);
        perr <= s[3:0] & s[7:4] & s[11:8];
        reg_wr <= s[12] & s[18];
        reg_rd <= s[13];
        addr <= adr[s[16:14]];
        wdata <= s[31:24];
      end
      // mid-run reset with both locks and the link already up
      @(negedge clk);
      {sys_rst, conv_i, link_i, link_en} <= 4'hf;
      {reg_wr, reg_rd, full, empty, perr} <= '0;
      repeat (3) @(negedge clk);
      sys_rst <= 1'b0;
      acc(1'b1, 1'b1, 12'h01f, 8'h14);
      acc(1'b0, 1'b1, 12'h0f0, 8'h00);
    end
    repeat (2) @(negedge clk);
    close_out();
  end
endmodule
bind ieb_top ieb_chk u_chk (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .conv_pll_lock_indicator(conv_pll_lock_indicator), .link_pll_lock_indicator(link_pll_lock_indicator),
  .link_enable(link_enable), .lane_fifo_full(lane_fifo_full), .lane_fifo_empty(lane_fifo_empty),
  .prbs_err(prbs_err), .irq(irq));
`default_nettype wire

// ===== rtl/ieb_consts.svh
`ifndef IEB_CONSTS_SVH
`define IEB_CONSTS_SVH

// ==========================================================
// widths
`define IEB_AW 12
`define IEB_DW 8
`define IEB_LANES 8
`define IEB_PRBS 4

// ==========================================================
// register addresses
`define IEB_ADDR_ENABLE0 12'h01f
`define IEB_ADDR_ENABLE1 12'h020
`define IEB_ADDR_FLAGS0 12'h0f0
`define IEB_ADDR_FLAGS1 12'h0f1
`define IEB_ADDR_FIFO_FULL 12'h30c
`define IEB_ADDR_FIFO_EMPTY 12'h30d

// ==========================================================
// reset values and masks
`define IEB_RST_BYTE 8'h00
`define IEB_ENABLE1_WMASK 8'h0f
`define IEB_RDATA_UNMAPPED 8'h00

// ==========================================================
// bit positions, shared by the first enable and first flag registers
`define IEB_BIT_CONV_LOSS 5
`define IEB_BIT_CONV_LOCK 4
`define IEB_BIT_LINK_LOSS 3
`define IEB_BIT_LINK_LOCK 2
`define IEB_BIT_LANE_ERR 1

// bit positions of the second enable and second flag registers
`define IEB_BIT_IMAG_B 3
`define IEB_BIT_REAL_B 2
`define IEB_BIT_IMAG_A 1
`define IEB_BIT_REAL_A 0

`endif

// ===== rtl/ieb_lane_err.sv
`timescale 1ns/1ps
`default_nettype none

`include "ieb_consts.svh"

module ieb_lane_err (
  input wire logic clk,
  input wire logic sys_rst,
  ieb_lane_if.tracker lif
);

  // ==========================================================
  // link re-enable detection
  logic link_en_prev;
  logic reenable;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link_en_prev <= 1'b0;
    end else begin
      link_en_prev <= lif.link_en;
    end
  end

  assign reenable = lif.link_en & ~link_en_prev;

  // ==========================================================
  // per-lane sticky flags, cleared only by a fresh link enable
  genvar i;
  generate
    for (i = 0; i < `IEB_LANES; i = i + 1) begin : g_lane
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          lif.sticky_full[i] <= 1'b0;
          lif.sticky_empty[i] <= 1'b0;
        end else begin
          // a new condition in the re-enable cycle survives the clear
          lif.sticky_full[i] <= (lif.sticky_full[i] & ~reenable) | (lif.full[i] & lif.link_en); // [RULE_06]
          lif.sticky_empty[i] <= (lif.sticky_empty[i] & ~reenable) | (lif.empty[i] & lif.link_en); // [RULE_06]
        end
      end
    end
  endgenerate

  // ==========================================================
  // summary error
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lif.any_err <= 1'b0;
    end else begin
      lif.any_err <= ((|lif.sticky_full) | (|lif.sticky_empty)) & ~reenable; // [RULE_05]
    end
  end

endmodule

`default_nettype wire

// ===== rtl/ieb_lane_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ieb_lane_if;
  ieb_pkg::ieb_lanes_t full;
  ieb_pkg::ieb_lanes_t empty;
  logic link_en;
  ieb_pkg::ieb_lanes_t sticky_full;
  ieb_pkg::ieb_lanes_t sticky_empty;
  logic any_err;

  modport tracker (
    input full,
    input empty,
    input link_en,
    output sticky_full,
    output sticky_empty,
    output any_err
  );

  modport core (
    output full,
    output empty,
    output link_en,
    input sticky_full,
    input sticky_empty,
    input any_err
  );
endinterface

`default_nettype wire

// ===== rtl/ieb_pkg.sv
`include "ieb_consts.svh"

package ieb_pkg;

  typedef logic [`IEB_DW-1:0] ieb_byte_t;
  typedef logic [`IEB_AW-1:0] ieb_addr_t;
  typedef logic [`IEB_LANES-1:0] ieb_lanes_t;
  typedef logic [`IEB_PRBS-1:0] ieb_prbs_t;

endpackage

// ===== rtl/ieb_top.sv
// Notes on behaviour
// RULE_01 - enable0 bit 5 lets converter PLL loss of lock raise the interrupt
// RULE_02 - enable0 bit 4 lets converter PLL reaching lock raise the interrupt
// RULE_03 - enable0 bit 3 lets link PLL loss of lock raise the interrupt
// RULE_04 - enable0 bit 2 lets link PLL reaching lock raise the interrupt
// RULE_05 - enable0 bit 1 lets any lane FIFO full or empty raise the interrupt
// RULE_06 - lane FIFO error holds until the link is disabled and enabled again
// RULE_07 - per-lane full flags read at 0x30c, empty flags at 0x30d
// RULE_08 - enable1 bit 3 lets pair B imaginary checker errors interrupt
// RULE_09 - enable1 bit 2 lets pair B real checker errors interrupt
// RULE_10 - enable1 bit 1 lets pair A imaginary checker errors interrupt
// RULE_11 - enable1 bit 0 lets pair A real checker errors interrupt
// RULE_12 - interrupt asserts while any enabled event flag is set, never otherwise

`timescale 1ns/1ps
`default_nettype none

`include "ieb_consts.svh"

module ieb_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ieb_pkg::ieb_addr_t reg_addr,
  input wire ieb_pkg::ieb_byte_t reg_wdata,
  output ieb_pkg::ieb_byte_t reg_rdata,
  output logic reg_rvalid,
  input wire logic conv_pll_lock_indicator,
  input wire logic link_pll_lock_indicator,
  input wire logic link_enable,
  input wire ieb_pkg::ieb_lanes_t lane_fifo_full,
  input wire ieb_pkg::ieb_lanes_t lane_fifo_empty,
  input wire ieb_pkg::ieb_prbs_t prbs_err,
  output logic irq
);

  // ==========================================================
  // register storage
  ieb_pkg::ieb_byte_t irq_enable_pll_fifo;
  ieb_pkg::ieb_byte_t irq_enable_prbs;

  // ==========================================================
  // write decode
  logic wr_enable0;
  logic wr_enable1;
  logic wr_flags0;
  logic wr_flags1;

  always_comb begin
    wr_enable0 = 1'b0;
    wr_enable1 = 1'b0;
    wr_flags0 = 1'b0;
    wr_flags1 = 1'b0;
    if (reg_wr && reg_addr == `IEB_ADDR_ENABLE0) begin
      wr_enable0 = 1'b1;
    end else if (reg_wr && reg_addr == `IEB_ADDR_ENABLE1) begin
      wr_enable1 = 1'b1;
    end else if (reg_wr && reg_addr == `IEB_ADDR_FLAGS0) begin
      wr_flags0 = 1'b1;
    end else if (reg_wr && reg_addr == `IEB_ADDR_FLAGS1) begin
      wr_flags1 = 1'b1;
    end
  end

  // ==========================================================
  // enable registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_enable_pll_fifo <= `IEB_RST_BYTE;
    end else if (wr_enable0) begin
      // reserved bits of this register are plain storage
      irq_enable_pll_fifo <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_enable_prbs <= `IEB_RST_BYTE;
    end else if (wr_enable1) begin
      // upper nibble is read-only zero
      irq_enable_prbs <= reg_wdata & `IEB_ENABLE1_WMASK;
    end
  end

  // ==========================================================
  // enable fields
  logic conv_pll_loss_irq_en;
  logic conv_pll_locked_irq_en;
  logic link_pll_loss_irq_en;
  logic link_pll_locked_irq_en;
  logic lane_buffer_error_irq_en;
  logic checker_imag_pair_b_irq_en;
  logic checker_real_pair_b_irq_en;
  logic checker_imag_pair_a_irq_en;
  logic checker_real_pair_a_irq_en;

  assign conv_pll_loss_irq_en = irq_enable_pll_fifo[`IEB_BIT_CONV_LOSS];
  assign conv_pll_locked_irq_en = irq_enable_pll_fifo[`IEB_BIT_CONV_LOCK];
  assign link_pll_loss_irq_en = irq_enable_pll_fifo[`IEB_BIT_LINK_LOSS];
  assign link_pll_locked_irq_en = irq_enable_pll_fifo[`IEB_BIT_LINK_LOCK];
  assign lane_buffer_error_irq_en = irq_enable_pll_fifo[`IEB_BIT_LANE_ERR];
  assign checker_imag_pair_b_irq_en = irq_enable_prbs[`IEB_BIT_IMAG_B];
  assign checker_real_pair_b_irq_en = irq_enable_prbs[`IEB_BIT_REAL_B];
  assign checker_imag_pair_a_irq_en = irq_enable_prbs[`IEB_BIT_IMAG_A];
  assign checker_real_pair_a_irq_en = irq_enable_prbs[`IEB_BIT_REAL_A];

  // ==========================================================
  // pll lock edge detection
  logic conv_lock_prev;
  logic link_lock_prev;
  logic conv_lock_rise;
  logic conv_lock_fall;
  logic link_lock_rise;
  logic link_lock_fall;

  // low after reset: a lock level already present at release is a lock event
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_lock_prev <= 1'b0;
    end else begin
      conv_lock_prev <= conv_pll_lock_indicator;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link_lock_prev <= 1'b0;
    end else begin
      link_lock_prev <= link_pll_lock_indicator;
    end
  end

  assign conv_lock_rise = conv_pll_lock_indicator & ~conv_lock_prev;
  assign conv_lock_fall = ~conv_pll_lock_indicator & conv_lock_prev;
  assign link_lock_rise = link_pll_lock_indicator & ~link_lock_prev;
  assign link_lock_fall = ~link_pll_lock_indicator & link_lock_prev;

  // ==========================================================
  // pll event flags, write one to clear, set wins
  logic conv_loss_flag;
  logic conv_lock_flag;
  logic link_loss_flag;
  logic link_lock_flag;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_loss_flag <= 1'b0;
    end else begin
      conv_loss_flag <= conv_lock_fall | (conv_loss_flag & ~(wr_flags0 & reg_wdata[`IEB_BIT_CONV_LOSS]));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_lock_flag <= 1'b0;
    end else begin
      conv_lock_flag <= conv_lock_rise | (conv_lock_flag & ~(wr_flags0 & reg_wdata[`IEB_BIT_CONV_LOCK]));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link_loss_flag <= 1'b0;
    end else begin
      link_loss_flag <= link_lock_fall | (link_loss_flag & ~(wr_flags0 & reg_wdata[`IEB_BIT_LINK_LOSS]));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link_lock_flag <= 1'b0;
    end else begin
      link_lock_flag <= link_lock_rise | (link_lock_flag & ~(wr_flags0 & reg_wdata[`IEB_BIT_LINK_LOCK]));
    end
  end

  // ==========================================================
  // checker event flags
  ieb_pkg::ieb_prbs_t prbs_flag;

  // every high cycle of an error input sets its flag again
  genvar k;
  generate
    for (k = 0; k < `IEB_PRBS; k = k + 1) begin : g_prbs
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          prbs_flag[k] <= 1'b0;
        end else begin
          prbs_flag[k] <= prbs_err[k] | (prbs_flag[k] & ~(wr_flags1 & reg_wdata[k]));
        end
      end
    end
  endgenerate

  // ==========================================================
  // lane fifo error tracking
  // stickies and their summary live in the lane tracker
  ieb_lane_if lif ();

  assign lif.full = lane_fifo_full;
  assign lif.empty = lane_fifo_empty;
  assign lif.link_en = link_enable;

  ieb_lane_err u_lane_err (
    .clk(clk),
    .sys_rst(sys_rst),
    .lif(lif)
  );

  // ==========================================================
  // gated events
  // an event whose enable is low never reaches the interrupt
  logic pend_conv_loss;
  logic pend_conv_lock;
  logic pend_link_loss;
  logic pend_link_lock;
  logic pend_lane;
  logic pend_imag_b;
  logic pend_real_b;
  logic pend_imag_a;
  logic pend_real_a;
  logic next_irq;

  assign pend_conv_loss = conv_loss_flag & conv_pll_loss_irq_en; // [RULE_01]
  assign pend_conv_lock = conv_lock_flag & conv_pll_locked_irq_en; // [RULE_02]
  assign pend_link_loss = link_loss_flag & link_pll_loss_irq_en; // [RULE_03]
  assign pend_link_lock = link_lock_flag & link_pll_locked_irq_en; // [RULE_04]
  assign pend_lane = lif.any_err & lane_buffer_error_irq_en; // [RULE_05]
  assign pend_imag_b = prbs_flag[`IEB_BIT_IMAG_B] & checker_imag_pair_b_irq_en; // [RULE_08]
  assign pend_real_b = prbs_flag[`IEB_BIT_REAL_B] & checker_real_pair_b_irq_en; // [RULE_09]
  assign pend_imag_a = prbs_flag[`IEB_BIT_IMAG_A] & checker_imag_pair_a_irq_en; // [RULE_10]
  assign pend_real_a = prbs_flag[`IEB_BIT_REAL_A] & checker_real_pair_a_irq_en; // [RULE_11]

  assign next_irq = pend_conv_loss | pend_conv_lock | pend_link_loss | pend_link_lock | pend_lane |
                    pend_imag_b | pend_real_b | pend_imag_a | pend_real_a; // [RULE_12]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq; // [RULE_12]
    end
  end

  // ==========================================================
  // flag register images
  ieb_pkg::ieb_byte_t flags0_image;
  ieb_pkg::ieb_byte_t flags1_image;

  always_comb begin
    flags0_image = `IEB_RST_BYTE;
    flags0_image[`IEB_BIT_CONV_LOSS] = conv_loss_flag;
    flags0_image[`IEB_BIT_CONV_LOCK] = conv_lock_flag;
    flags0_image[`IEB_BIT_LINK_LOSS] = link_loss_flag;
    flags0_image[`IEB_BIT_LINK_LOCK] = link_lock_flag;
    flags0_image[`IEB_BIT_LANE_ERR] = lif.any_err;
    flags1_image = `IEB_RST_BYTE;
    flags1_image[`IEB_PRBS-1:0] = prbs_flag;
  end

  // ==========================================================
  // read path, one cycle after the strobe
  // a read with a write in one cycle returns the pre-write value
  ieb_pkg::ieb_byte_t next_rdata;

  always_comb begin
    next_rdata = `IEB_RDATA_UNMAPPED;
    if (reg_addr == `IEB_ADDR_ENABLE0) begin
      next_rdata = irq_enable_pll_fifo;
    end else if (reg_addr == `IEB_ADDR_ENABLE1) begin
      next_rdata = irq_enable_prbs;
    end else if (reg_addr == `IEB_ADDR_FLAGS0) begin
      next_rdata = flags0_image;
    end else if (reg_addr == `IEB_ADDR_FLAGS1) begin
      next_rdata = flags1_image;
    end else if (reg_addr == `IEB_ADDR_FIFO_FULL) begin
      next_rdata = lif.sticky_full; // [RULE_07]
    end else if (reg_addr == `IEB_ADDR_FIFO_EMPTY) begin
      next_rdata = lif.sticky_empty; // [RULE_07]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // read data holds until the next read strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= `IEB_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire
